/* kslp_pkg.sv */
// Purpose: shared constants and types of the keypad scan and LED driver
// Assumes: byte-wide register access, 8 pins, osc ticks as one-cycle pulses
// Notes:   LED pin registers sit at LED_BASE + pin*8 + field
package kslp_pkg;
	// register offsets
	localparam logic [7:0] ADDR_KEY_CFG  = 8'h14;
	localparam logic [7:0] ADDR_KEY_CODE = 8'h15;
	localparam logic [7:0] ADDR_HIGH_IN  = 8'h2a;
	localparam logic [7:0] ADDR_SW_RESET = 8'h7d;
	localparam logic [1:0] LED_WINDOW    = 2'h2;
	localparam logic [2:0] LED_F_TON     = 3'h0;
	localparam logic [2:0] LED_F_ION     = 3'h1;
	localparam logic [2:0] LED_F_OFF     = 3'h2;
	localparam logic [2:0] LED_F_RISE    = 3'h3;
	localparam logic [2:0] LED_F_FALL    = 3'h4;
	// reset values
	localparam logic [7:0] KEY_CFG_RST   = 8'h00;
	localparam logic [7:0] KEY_CODE_IDLE = 8'hff;
	localparam logic [7:0] HIGH_IN_RST   = 8'h00;
	localparam logic [4:0] TIME5_RST     = 5'h00;
	localparam logic [7:0] ION_RST       = 8'hff;
	localparam logic [7:0] OFF_RST       = 8'h00;
	// software reset key sequence
	localparam logic [7:0] SW_KEY_FIRST  = 8'h12;
	localparam logic [7:0] SW_KEY_SECOND = 8'h34;
	// key config field positions
	localparam int KEY_ROWS_LSB = 5;
	localparam int KEY_COLS_LSB = 3;
	localparam int KEY_TIME_LSB = 0;
	localparam int COL_PIN_BASE = 4;
	// scan time: 1 ms at a 2 MHz oscillator, in oscillator ticks
	localparam int SCAN_BASE_US  = 1000;
	localparam int OSC_REF_MHZ   = 2;
	localparam int SCAN_BASE_OSC = SCAN_BASE_US * OSC_REF_MHZ;
	// led timing
	localparam logic [7:0] PWM_CNT_MAX = 8'hfe;
	localparam logic [1:0] OSC_OFF     = 2'h0;
	localparam logic [7:0] FADE_PINS   = 8'h88;
	typedef enum logic [1:0] {
		LED_OFF  = 2'b00,
		LED_RISE = 2'b01,
		LED_ON   = 2'b10,
		LED_FALL = 2'b11
	} kslp_led_state_t;
	typedef enum logic [1:0] {
		KEY_IDLE = 2'b00,
		KEY_SCAN = 2'b01,
		KEY_HOLD = 2'b10
	} kslp_key_state_t;
endpackage : kslp_pkg

/* kslp_led_channel.sv */
// Purpose: one pin's blink, intensity and fade engine
// Assumes: tick is one pulse per led tick clock period
// Notes:   durations counted in pwm periods of 255 ticks
`timescale 1ns/10ps
module kslp_led_channel #(
	parameter bit FADE_OK = 1'b0
) (
	// clock and reset
	input  wire logic       ref_clk,
	input  wire logic       rst_n,
	input  wire logic       clear,
	// control
	input  wire logic       enable,
	input  wire logic       tick,
	input  wire logic       data_bit,
	input  wire logic       log_mode,
	// settings
	input  wire logic [4:0] ton,
	input  wire logic [7:0] ion,
	input  wire logic [4:0] toff,
	input  wire logic [2:0] ioff,
	input  wire logic [4:0] trise,
	input  wire logic [4:0] tfall,
	// drive
	output logic            pwm_out
);
	kslp_pkg::kslp_led_state_t state, next_state;
	logic [7:0]  pwm_cnt, next_pwm_cnt, level, next_level, off_lvl, out_lvl;
	logic [13:0] dur_cnt, next_dur_cnt, on_len, off_len;
	logic [8:0]  step_cnt, next_step_cnt, rise_step, fall_step;
	logic        data_q, next_pwm_out, period_end, start_on, end_on;
	logic [15:0] squared;

	always_comb
	begin
		off_lvl = {ioff, 2'b00};
		on_len = ton[4] ? {ton, 9'h000} : {3'h0, ton, 6'h00};
		off_len = toff[4] ? {toff, 9'h000} : {3'h0, toff, 6'h00};
		rise_step = trise[4] ? {trise, 4'h0} : {4'h0, trise};
		fall_step = tfall[4] ? {tfall, 4'h0} : {4'h0, tfall};
		period_end = tick && pwm_cnt == kslp_pkg::PWM_CNT_MAX;
		// static mode follows data; single shot waits for a falling data bit
		start_on = !data_bit && (ton == 5'h00 || (toff == 5'h00 ?
			data_q : dur_cnt >= off_len));
		end_on = data_bit || (ton != 5'h00 && dur_cnt >= on_len);
		next_state = state;
		next_level = level;
		next_step_cnt = step_cnt;
		next_pwm_cnt = !tick ? pwm_cnt :
			(pwm_cnt == kslp_pkg::PWM_CNT_MAX ? 8'h00 : pwm_cnt + 8'h01);
		next_dur_cnt = (period_end && dur_cnt != 14'h3fff) ?
			dur_cnt + 14'h0001 : dur_cnt;
		unique case (state)
			kslp_pkg::LED_OFF:
			begin
				next_level = off_lvl;
				if (start_on)
				begin
					next_dur_cnt = 14'h0000;
					next_step_cnt = 9'h000;
					next_state = trise != 5'h00 ? kslp_pkg::LED_RISE
						: kslp_pkg::LED_ON;
				end
			end
			kslp_pkg::LED_RISE:
			begin
				if (level >= ion || data_bit)
				begin
					next_state = kslp_pkg::LED_ON;
					next_dur_cnt = 14'h0000;
				end
				else if (period_end)
				begin
					next_step_cnt = step_cnt + 9'h001;
					if (step_cnt + 9'h001 >= rise_step)
					begin
						next_step_cnt = 9'h000;
						next_level = level + 8'h01;
					end
				end
			end
			kslp_pkg::LED_ON:
			begin
				next_level = ion;
				if (end_on)
				begin
					next_dur_cnt = 14'h0000;
					next_step_cnt = 9'h000;
					next_state = tfall != 5'h00 ? kslp_pkg::LED_FALL
						: kslp_pkg::LED_OFF;
				end
			end
			kslp_pkg::LED_FALL:
			begin
				if (level <= off_lvl)
				begin
					next_state = kslp_pkg::LED_OFF;
					next_dur_cnt = 14'h0000;
				end
				else if (period_end)
				begin
					next_step_cnt = step_cnt + 9'h001;
					if (step_cnt + 9'h001 >= fall_step)
					begin
						next_step_cnt = 9'h000;
						next_level = level - 8'h01;
					end
				end
			end
		endcase
		squared = {8'h00, level} * {8'h00, level};
		// log curve is a square law; only fade capable pins use it
		out_lvl = (FADE_OK && log_mode) ? squared[15:8] : level;
		next_pwm_out = enable && pwm_cnt < out_lvl;
		if (!enable || clear)
		begin
			next_state = kslp_pkg::LED_OFF;
			next_level = off_lvl;
			next_pwm_cnt = 8'h00;
			next_dur_cnt = 14'h0000;
			next_step_cnt = 9'h000;
		end
	end

	always_ff @(posedge ref_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			state <= kslp_pkg::LED_OFF;
			level <= 8'h00;
			pwm_cnt <= 8'h00;
			dur_cnt <= 14'h0000;
			step_cnt <= 9'h000;
			data_q <= 1'b1;
			pwm_out <= 1'b0;
		end
		else
		begin
			state <= next_state;
			level <= next_level;
			pwm_cnt <= next_pwm_cnt;
			dur_cnt <= next_dur_cnt;
			step_cnt <= next_step_cnt;
			data_q <= data_bit;
			pwm_out <= next_pwm_out;
		end
	end
endmodule : kslp_led_channel

/* kslp_engine.sv */
// Purpose: keypad scan engine, led driver registers and software reset
// Assumes: register access decoded by the serial front end, one byte a cycle
// Notes:   scan and led timing advance on oscillator tick pulses
// What this block does
// - Two-bit row field: 00 disables scan, else 2, 3 or 4 rows.
// - Two-bit column field selects 1 to 4 columns from pin 4 up.
// - Row scan time 1 ms doubling per code to 128 ms.
// - Key code is active low, one row and one column zero; idles 0xFF.
// - Reading the key code clears it, releases the irq, resumes scanning.
// - Zero on-time means static mode driven by the pin data bit.
// - On-time 1-15 gives 64*v*255 ticks, 16-31 gives 512*v*255.
// - On level is the intensity byte, log mapped on fade pins.
// - Zero off-time means single shot mode driven by the data bit.
// - Off-time 1-15 gives 64*v*255 ticks, 16-31 gives 512*v*255.
// - Off level is four times the three-bit off intensity.
// - Fade-in zero disables; else step time v, sixteenfold above 15.
// - Fade-out zero disables; else step time v, sixteenfold above 15.
// - Writing 0x12 then 0x34 resets all state; register reads zero.
// - Led tick is osc divided by 2^(field-1); zero field disables.
// - Oscillator source off disables led driver and keypad engine.
// - Led driver acts only on output pins with led enable set.
`timescale 1ns/10ps
module kslp_engine #(
	parameter int         N_PINS    = 8,
	parameter int         SCAN_BASE = kslp_pkg::SCAN_BASE_OSC,
	parameter logic [7:0] FADE_MASK = kslp_pkg::FADE_PINS
) (
	// clock and reset
	input  wire logic       ref_clk,
	input  wire logic       rst_n,
	// register access
	input  wire logic [7:0] reg_addr,
	input  wire logic [7:0] reg_wdata,
	input  wire logic       reg_wr,
	input  wire logic       reg_rd,
	output logic      [7:0] reg_rdata,
	// device settings
	input  wire logic       osc_tick,
	input  wire logic [1:0] osc_source,
	input  wire logic [2:0] led_clk_div,
	input  wire logic       log_mode_a,
	input  wire logic       log_mode_b,
	input  wire logic [7:0] led_enable_bits,
	input  wire logic [7:0] pin_dir,
	input  wire logic [7:0] pin_data_bits,
	input  wire logic [7:0] pin_in,
	// pin drive
	output logic      [7:0] led_drive,
	output logic      [7:0] led_active,
	output logic      [3:0] row_drive,
	output logic      [3:0] row_oe_n,
	// status
	output logic            irq_out_n,
	output logic      [7:0] high_input_enable,
	output logic            device_reset_req
);
	if (N_PINS != 8)
		$error("kslp_engine serves exactly eight pins");
	if (SCAN_BASE < 1 || SCAN_BASE > 2047)
		$error("kslp_engine scan base out of counter range");

	localparam logic [17:0] SCAN_BASE_W = 18'(SCAN_BASE);
	localparam int KEY_ROWS_HI = kslp_pkg::KEY_ROWS_LSB + 1;
	localparam int KEY_COLS_HI = kslp_pkg::KEY_COLS_LSB + 1;
	localparam int KEY_TIME_HI = kslp_pkg::KEY_TIME_LSB + 2;

	logic [7:0]  key_cfg, next_key_cfg, next_high_in, next_rdata;
	logic [7:0]  key_code, next_key_code;
	logic        sw_armed, next_sw_armed, sw_rst, next_sw_rst;
	logic        osc_on, wr_key_cfg, rd_key_code;
	logic [4:0]  led_ton   [8];
	logic [7:0]  led_ion   [8];
	logic [7:0]  led_off   [8];
	logic [4:0]  led_rise  [8];
	logic [4:0]  led_fall  [8];
	logic        led_sel;
	logic [2:0]  led_pin, led_field;

	always_comb
	begin
		osc_on = osc_source != kslp_pkg::OSC_OFF;
		led_sel = reg_addr[7:6] == kslp_pkg::LED_WINDOW;
		led_pin = reg_addr[5:3];
		led_field = reg_addr[2:0];
		wr_key_cfg = reg_wr && reg_addr == kslp_pkg::ADDR_KEY_CFG;
		rd_key_code = reg_rd && reg_addr == kslp_pkg::ADDR_KEY_CODE;
		next_key_cfg = wr_key_cfg ? reg_wdata : key_cfg;
		next_high_in = (reg_wr && reg_addr == kslp_pkg::ADDR_HIGH_IN) ?
			reg_wdata : high_input_enable;
		// any write between the two keys breaks the sequence
		next_sw_armed = reg_wr ? (reg_addr == kslp_pkg::ADDR_SW_RESET &&
			reg_wdata == kslp_pkg::SW_KEY_FIRST) : sw_armed;
		next_sw_rst = reg_wr && sw_armed &&
			reg_addr == kslp_pkg::ADDR_SW_RESET &&
			reg_wdata == kslp_pkg::SW_KEY_SECOND;
		next_rdata = 8'h00;
		if (reg_rd)
		begin
			if (led_sel)
			begin
				unique case (led_field)
					kslp_pkg::LED_F_TON:  next_rdata = {3'h0, led_ton[led_pin]};
					kslp_pkg::LED_F_ION:  next_rdata = led_ion[led_pin];
					kslp_pkg::LED_F_OFF:  next_rdata = led_off[led_pin];
					kslp_pkg::LED_F_RISE: next_rdata = {3'h0, led_rise[led_pin]};
					kslp_pkg::LED_F_FALL: next_rdata = {3'h0, led_fall[led_pin]};
					default:              next_rdata = 8'h00;
				endcase
			end
			else if (reg_addr == kslp_pkg::ADDR_KEY_CFG)
				next_rdata = key_cfg;
			else if (reg_addr == kslp_pkg::ADDR_KEY_CODE)
				next_rdata = key_code;
			else if (reg_addr == kslp_pkg::ADDR_HIGH_IN)
				next_rdata = high_input_enable;
			// reset register and unmapped addresses read zero
		end
	end

	always_ff @(posedge ref_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			key_cfg <= kslp_pkg::KEY_CFG_RST;
			high_input_enable <= kslp_pkg::HIGH_IN_RST;
			sw_armed <= 1'b0;
			sw_rst <= 1'b0;
			device_reset_req <= 1'b0;
			reg_rdata <= 8'h00;
		end
		else if (sw_rst)
		begin
			key_cfg <= kslp_pkg::KEY_CFG_RST;
			high_input_enable <= kslp_pkg::HIGH_IN_RST;
			sw_armed <= 1'b0;
			sw_rst <= 1'b0;
			device_reset_req <= 1'b0;
			reg_rdata <= 8'h00;
		end
		else
		begin
			key_cfg <= next_key_cfg;
			high_input_enable <= next_high_in;
			sw_armed <= next_sw_armed;
			sw_rst <= next_sw_rst;
			device_reset_req <= next_sw_rst;
			reg_rdata <= next_rdata;
		end
	end

	// keypad scan
	kslp_pkg::kslp_key_state_t key_state, next_key_state;
	logic [1:0]  row_idx, next_row_idx, rows_f, cols_f;
	logic [17:0] scan_cnt, next_scan_cnt, scan_len;
	logic [3:0]  row_en, col_en, col_hit, next_row_drive, next_row_oe_n;
	logic        scan_en, next_irq_n;
	logic [1:0]  hit_col;

	always_comb
	begin
		rows_f = key_cfg[KEY_ROWS_HI:kslp_pkg::KEY_ROWS_LSB];
		cols_f = key_cfg[KEY_COLS_HI:kslp_pkg::KEY_COLS_LSB];
		scan_len = SCAN_BASE_W << key_cfg[KEY_TIME_HI:kslp_pkg::KEY_TIME_LSB];
		row_en = 4'((5'b00010 << rows_f) - 5'b00001);
		col_en = 4'((5'b00010 << cols_f) - 5'b00001);
		scan_en = rows_f != 2'b00 && osc_on;
		col_hit = ~pin_in[kslp_pkg::COL_PIN_BASE +: 4] & col_en;
		hit_col = 2'd0;
		for (int c = 3; c >= 0; c--)
			if (col_hit[c])
				hit_col = 2'(c);
		next_key_state = key_state;
		next_key_code = key_code;
		next_row_idx = row_idx;
		next_scan_cnt = scan_cnt;
		next_irq_n = irq_out_n;
		if (rd_key_code)
		begin
			next_key_code = kslp_pkg::KEY_CODE_IDLE;
			next_irq_n = 1'b1;
			if (key_state == kslp_pkg::KEY_HOLD)
			begin
				next_key_state = kslp_pkg::KEY_SCAN;
				next_scan_cnt = 18'h0_0000;
			end
		end
		unique case (key_state)
			kslp_pkg::KEY_IDLE:
			begin
				next_row_idx = 2'd0;
				next_scan_cnt = 18'h0_0000;
				if (scan_en)
					next_key_state = kslp_pkg::KEY_SCAN;
			end
			kslp_pkg::KEY_SCAN:
			begin
				if (osc_tick)
					next_scan_cnt = scan_cnt + 18'h0_0001;
				if (osc_tick && scan_cnt + 18'h0_0001 >= scan_len)
				begin
					next_scan_cnt = 18'h0_0000;
					if (col_hit != 4'h0)
					begin
						// set wins over a read in the same cycle
						next_key_code = ~(8'(8'h10 << hit_col) |
							8'(8'h01 << row_idx));
						next_irq_n = 1'b0;
						next_key_state = kslp_pkg::KEY_HOLD;
					end
					else
						next_row_idx = row_idx == rows_f ? 2'd0
							: row_idx + 2'd1;
				end
			end
			kslp_pkg::KEY_HOLD:
			begin
			end
			default:
				next_key_state = kslp_pkg::KEY_IDLE;
		endcase
		if (!scan_en)
		begin
			next_key_state = kslp_pkg::KEY_IDLE;
			next_row_idx = 2'd0;
			next_scan_cnt = 18'h0_0000;
		end
		next_row_drive = ~(4'h1 << next_row_idx);
		next_row_oe_n = next_key_state == kslp_pkg::KEY_IDLE ? 4'hf : ~row_en;
	end

	always_ff @(posedge ref_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			key_state <= kslp_pkg::KEY_IDLE;
			key_code <= kslp_pkg::KEY_CODE_IDLE;
			row_idx <= 2'd0;
			scan_cnt <= 18'h0_0000;
			irq_out_n <= 1'b1;
			row_drive <= 4'hf;
			row_oe_n <= 4'hf;
		end
		else if (sw_rst)
		begin
			key_state <= kslp_pkg::KEY_IDLE;
			key_code <= kslp_pkg::KEY_CODE_IDLE;
			row_idx <= 2'd0;
			scan_cnt <= 18'h0_0000;
			irq_out_n <= 1'b1;
			row_drive <= 4'hf;
			row_oe_n <= 4'hf;
		end
		else
		begin
			key_state <= next_key_state;
			key_code <= next_key_code;
			row_idx <= next_row_idx;
			scan_cnt <= next_scan_cnt;
			irq_out_n <= next_irq_n;
			row_drive <= next_row_drive;
			row_oe_n <= next_row_oe_n;
		end
	end

	// led tick divider
	logic [5:0] div_cnt, next_div_cnt, div_last;
	logic       led_tick, next_led_tick, led_run;

	always_comb
	begin
		led_run = osc_on && led_clk_div != 3'h0;
		div_last = 6'((7'h01 << (led_clk_div - 3'h1)) - 7'h01);
		next_div_cnt = div_cnt;
		next_led_tick = 1'b0;
		if (!led_run)
			next_div_cnt = 6'h00;
		else if (osc_tick)
		begin
			next_led_tick = div_cnt >= div_last;
			next_div_cnt = div_cnt >= div_last ? 6'h00 : div_cnt + 6'h01;
		end
	end

	always_ff @(posedge ref_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			div_cnt <= 6'h00;
			led_tick <= 1'b0;
		end
		else
		begin
			div_cnt <= sw_rst ? 6'h00 : next_div_cnt;
			led_tick <= sw_rst ? 1'b0 : next_led_tick;
		end
	end

	// per pin led registers and engines
	for (genvar p = 0; p < 8; p++)
	begin : g_pin
		logic       wr_pin, next_act;
		logic [4:0] next_ton, next_rise, next_fall;
		logic [7:0] next_ion, next_off;

		always_comb
		begin
			wr_pin = reg_wr && led_sel && led_pin == 3'(p);
			next_ton = (wr_pin && led_field == kslp_pkg::LED_F_TON) ?
				reg_wdata[4:0] : led_ton[p];
			next_ion = (wr_pin && led_field == kslp_pkg::LED_F_ION) ?
				reg_wdata : led_ion[p];
			next_off = (wr_pin && led_field == kslp_pkg::LED_F_OFF) ?
				reg_wdata : led_off[p];
			next_rise = (wr_pin && led_field == kslp_pkg::LED_F_RISE) ?
				reg_wdata[4:0] : led_rise[p];
			next_fall = (wr_pin && led_field == kslp_pkg::LED_F_FALL) ?
				reg_wdata[4:0] : led_fall[p];
			next_act = led_run && led_enable_bits[p] && !pin_dir[p];
		end

		always_ff @(posedge ref_clk or negedge rst_n)
		begin
			if (!rst_n)
			begin
				led_ton[p] <= kslp_pkg::TIME5_RST;
				led_ion[p] <= kslp_pkg::ION_RST;
				led_off[p] <= kslp_pkg::OFF_RST;
				led_rise[p] <= kslp_pkg::TIME5_RST;
				led_fall[p] <= kslp_pkg::TIME5_RST;
				led_active[p] <= 1'b0;
			end
			else
			begin
				led_ton[p] <= sw_rst ? kslp_pkg::TIME5_RST : next_ton;
				led_ion[p] <= sw_rst ? kslp_pkg::ION_RST : next_ion;
				led_off[p] <= sw_rst ? kslp_pkg::OFF_RST : next_off;
				led_rise[p] <= sw_rst ? kslp_pkg::TIME5_RST : next_rise;
				led_fall[p] <= sw_rst ? kslp_pkg::TIME5_RST : next_fall;
				led_active[p] <= sw_rst ? 1'b0 : next_act;
			end
		end

		kslp_led_channel #(
			.FADE_OK (FADE_MASK[p])
		) u_chan (
			.ref_clk  (ref_clk),
			.rst_n    (rst_n),
			.clear    (sw_rst),
			.enable   (led_active[p]),
			.tick     (led_tick),
			.data_bit (pin_data_bits[p]),
			.log_mode (p < 4 ? log_mode_a : log_mode_b),
			.ton      (led_ton[p]),
			.ion      (led_ion[p]),
			.toff     (led_off[p][7:3]),
			.ioff     (led_off[p][2:0]),
			.trise    (led_rise[p]),
			.tfall    (led_fall[p]),
			.pwm_out  (led_drive[p])
		);
	end
endmodule : kslp_engine

/* kslp_chk.sv */
// Purpose: port-level checker for the keypad scan and led engine
// Assumes: one clock domain, asynchronous active-low reset
// Notes:   bound onto kslp_engine from the testbench top file
`timescale 1ns/10ps
module kslp_chk (
	// clock and reset
	input wire logic       ref_clk,
	input wire logic       rst_n,
	// register access
	input wire logic [7:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	input wire logic       reg_wr,
	input wire logic       reg_rd,
	input wire logic [7:0] reg_rdata,
	// settings
	input wire logic [1:0] osc_source,
	input wire logic [2:0] led_clk_div,
	input wire logic [7:0] led_enable_bits,
	input wire logic [7:0] pin_dir,
	// outputs
	input wire logic [7:0] led_drive,
	input wire logic [7:0] led_active,
	input wire logic [3:0] row_drive,
	input wire logic [3:0] row_oe_n,
	input wire logic       irq_out_n,
	input wire logic [7:0] high_input_enable,
	input wire logic       device_reset_req
);
	default clocking cb @(posedge ref_clk);
	endclocking
	default disable iff (!rst_n);
	logic [7:0] gate_v;
	logic       code_rd;
	logic       sw_sel;
	assign gate_v  = (osc_source != 2'h0 && led_clk_div != 3'h0) ?
		(led_enable_bits & ~pin_dir) : 8'h00;
	assign code_rd = reg_rd && reg_addr == kslp_pkg::ADDR_KEY_CODE;
	assign sw_sel  = reg_addr == kslp_pkg::ADDR_SW_RESET;
	sequence s_first;
		reg_wr && sw_sel && reg_wdata == kslp_pkg::SW_KEY_FIRST;
	endsequence
	sequence s_key;
		s_first ##1 !reg_wr ##1
			(reg_wr && sw_sel && reg_wdata == kslp_pkg::SW_KEY_SECOND);
	endsequence
	property p_sw_read;
		reg_rd && sw_sel |=> reg_rdata == 8'h00;
	endproperty
	a_sw_read: assert property (p_sw_read)
		else $error("reset register read not zero");
	property p_sw_reset;
		s_key |=> device_reset_req ##1 (high_input_enable == 8'h00 && irq_out_n);
	endproperty
	a_sw_reset: assert property (p_sw_reset)
		else $error("key sequence did not reset");
	property p_code_clear;
		code_rd && !irq_out_n |=> irq_out_n;
	endproperty
	a_code_clear: assert property (p_code_clear)
		else $error("code read did not release irq");
	property p_irq_hold;
		!irq_out_n && !code_rd && !device_reset_req |=> !irq_out_n;
	endproperty
	a_irq_hold: assert property (p_irq_hold)
		else $error("irq released without code read");
	property p_osc_off;
		osc_source == 2'h0 [*3] |-> row_oe_n == 4'hf && led_active == 8'h00;
	endproperty
	a_osc_off: assert property (p_osc_off)
		else $error("engine active with oscillator off");
	property p_led_gate;
		1'b1 |=> led_active == $past(gate_v);
	endproperty
	a_led_gate: assert property (p_led_gate)
		else $error("led ownership does not follow gating");
	property p_dark;
		led_active == 8'h00 [*2] |-> led_drive == 8'h00;
	endproperty
	a_dark: assert property (p_dark)
		else $error("inactive pin driven");
	property p_row_one;
		row_oe_n != 4'hf |-> $onehot0(~row_drive & ~row_oe_n);
	endproperty
	a_row_one: assert property (p_row_one)
		else $error("more than one row active");
	property p_irq_scan;
		$fell(irq_out_n) |-> row_oe_n != 4'hf;
	endproperty
	a_irq_scan: assert property (p_irq_scan)
		else $error("key latched while not scanning");
endmodule : kslp_chk

/* kslp_host_model.sv */
// Purpose: host side of the register port
// Assumes: strobes taken on the rising edge, data back one cycle later
// Notes:   drives on falling edges, scrambles the bus when idle
`timescale 1ns/10ps
module kslp_host_model (
	// clock
	input  wire logic       ref_clk,
	// register access
	output logic      [7:0] reg_addr,
	output logic      [7:0] reg_wdata,
	output logic            reg_wr,
	output logic            reg_rd,
	input  wire logic [7:0] reg_rdata
);
	initial
	begin
		reg_addr  = 8'h00;
		reg_wdata = 8'h00;
		reg_wr    = 1'b0;
		reg_rd    = 1'b0;
	end
	// released lines invert so stale values never look valid
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(negedge ref_clk);
		reg_addr  = a;
		reg_wdata = d;
		reg_wr    = 1'b1;
		@(negedge ref_clk);
		reg_wr    = 1'b0;
		reg_addr  = ~a;
		reg_wdata = ~d;
	endtask : wr
	task automatic rd(input logic [7:0] a, output logic [7:0] d);
		@(negedge ref_clk);
		reg_addr = a;
		reg_rd   = 1'b1;
		@(negedge ref_clk);
		reg_rd   = 1'b0;
		reg_addr = ~a;
		d        = reg_rdata;
	endtask : rd
	task automatic sw_reset;
		wr(kslp_pkg::ADDR_SW_RESET, kslp_pkg::SW_KEY_FIRST);
		wr(kslp_pkg::ADDR_SW_RESET, kslp_pkg::SW_KEY_SECOND);
	endtask : sw_reset
endmodule : kslp_host_model

/* tb.sv */
// Purpose: self-checking bench for the keypad scan and led engine
// Assumes: osc tick every clock, scan base shortened to 4 ticks
// Notes:   pin 0 carries the led checks, a modelled key the scan checks
`timescale 1ns/10ps
module tb;
	logic       ref_clk, rst_n, reg_wr, reg_rd, osc_tick;
	logic       log_mode_a, log_mode_b, irq_out_n, device_reset_req;
	logic [7:0] reg_addr, reg_wdata, reg_rdata, led_enable_bits, pin_dir;
	logic [7:0] pin_data_bits, pin_in, led_drive, led_active;
	logic [7:0] high_input_enable;
	logic [1:0] osc_source, key_row, key_col;
	logic [2:0] led_clk_div;
	logic [3:0] row_drive, row_oe_n;
	logic       key_on, hit;
	int         errors, compares;
	// key closes its column only while its row is actively pulled low
	assign hit    = key_on && !row_oe_n[key_row] && !row_drive[key_row];
	assign pin_in = ~(8'(hit) << (3'd4 + 3'(key_col)));
	kslp_engine #(.SCAN_BASE(4)) u_dut (.ref_clk(ref_clk), .rst_n(rst_n),
		.reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
		.reg_rd(reg_rd), .reg_rdata(reg_rdata), .osc_tick(osc_tick),
		.osc_source(osc_source), .led_clk_div(led_clk_div),
		.log_mode_a(log_mode_a), .log_mode_b(log_mode_b),
		.led_enable_bits(led_enable_bits), .pin_dir(pin_dir),
		.pin_data_bits(pin_data_bits), .pin_in(pin_in),
		.led_drive(led_drive), .led_active(led_active),
		.row_drive(row_drive), .row_oe_n(row_oe_n), .irq_out_n(irq_out_n),
		.high_input_enable(high_input_enable),
		.device_reset_req(device_reset_req));
	kslp_host_model u_host (.ref_clk(ref_clk), .reg_addr(reg_addr),
		.reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
		.reg_rdata(reg_rdata));
	always #12.5 ref_clk = ~ref_clk;
	task automatic check(input string what, input logic [31:0] seen,
		input logic [31:0] exp);
		compares++;
		if (seen !== exp)
		begin
			errors++;
			$display("BAD %s expected %0h seen %0h", what, exp, seen);
		end
	endtask : check
	task automatic close_out;
		$display("compares %0d errors %0d", compares, errors);
		if (errors == 0 && compares > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask : close_out
	task automatic rchk(input logic [7:0] a, input logic [7:0] e);
		logic [7:0] v;
		u_host.rd(a, v);
		check($sformatf("reg %0h", a), v, e);
	endtask : rchk
	task automatic t_swrst;
		u_host.wr(kslp_pkg::ADDR_HIGH_IN, 8'ha5);
		rchk(kslp_pkg::ADDR_HIGH_IN, 8'ha5);
		check("hie port", high_input_enable, 8'ha5);
		u_host.wr(kslp_pkg::ADDR_SW_RESET, kslp_pkg::SW_KEY_FIRST);
		u_host.wr(kslp_pkg::ADDR_HIGH_IN, 8'h5a);
		u_host.wr(kslp_pkg::ADDR_SW_RESET, kslp_pkg::SW_KEY_SECOND);
		rchk(kslp_pkg::ADDR_HIGH_IN, 8'h5a);
		u_host.sw_reset;
		check("reset req", device_reset_req, 1'b1);
		rchk(kslp_pkg::ADDR_HIGH_IN, 8'h00);
	endtask : t_swrst
	// scan times used here stay above any debounce time
	task automatic key_try(input logic [7:0] cfg, input logic [1:0] r, c,
		input logic [7:0] code);
		int         i;
		logic [7:0] v;
		u_host.wr(kslp_pkg::ADDR_KEY_CFG, cfg);
		key_row = r;
		key_col = c;
		key_on  = 1'b1;
		for (i = 0; i < 400 && irq_out_n === 1'b1; i++)
			@(negedge ref_clk);
		check("irq", irq_out_n, code == 8'hff);
		if (code != 8'hff)
		begin
			u_host.rd(kslp_pkg::ADDR_KEY_CODE, v);
			check("key code", v, code);
			check("irq release", irq_out_n, 1'b1);
		end
		key_on = 1'b0;
	endtask : key_try
	task automatic row_time(input logic [2:0] t);
		int n;
		u_host.wr(kslp_pkg::ADDR_KEY_CFG, {5'b00100, t});
		for (n = 0; n < 3000 && row_drive[0] !== 1'b1; n++)
			@(negedge ref_clk);
		for (n = 0; n < 3000 && row_drive[0] !== 1'b0; n++)
			@(negedge ref_clk);
		for (n = 0; n < 3000 && row_drive[0] === 1'b0; n++)
			@(negedge ref_clk);
		check("row time", n, 4 << t);
	endtask : row_time
	task automatic duty(input string what, input logic [7:0] lvl, int d);
		int n;
		n = 0;
		repeat (600) @(negedge ref_clk);
		repeat (255 << (d - 1))
		begin
			@(negedge ref_clk);
			n += int'(led_drive[0]);
		end
		check(what, n, 32'(lvl) << (d - 1));
	endtask : duty
	task automatic t_levels;
		pin_dir         = 8'hfe;
		led_enable_bits = 8'h01;
		u_host.wr(8'h81, 8'h40);
		u_host.wr(8'h82, 8'h03);
		for (int d = 1; d < 3; d++)
		begin
			led_clk_div      = 3'(d);
			pin_data_bits[0] = 1'b0;
			duty("on level", 8'h40, d);
			pin_data_bits[0] = 1'b1;
			duty("off level", 8'(4 * 3), d);
		end
		check("active", led_active[0], 1'b1);
		led_clk_div = 3'h0;
		repeat (4) @(negedge ref_clk);
		check("div off", led_active[0], 1'b0);
		led_clk_div = 3'h1;
		pin_dir[0]  = 1'b1;
		repeat (4) @(negedge ref_clk);
		check("input pin", {led_active[0], led_drive[0]}, 2'b00);
		u_host.wr(kslp_pkg::ADDR_KEY_CFG, 8'h28);
		osc_source = 2'h0;
		repeat (4) @(negedge ref_clk);
		check("osc off", row_oe_n, 4'hf);
		osc_source = 2'h2;
	endtask : t_levels
	task automatic span(input logic lvl, output int n);
		for (n = 0; n < 20000 && led_drive[0] !== lvl; n++)
			@(negedge ref_clk);
		for (n = 0; n < 20000 && led_drive[0] === lvl; n++)
			@(negedge ref_clk);
	endtask : span
	task automatic t_blink;
		int n;
		pin_dir          = 8'hfe;
		pin_data_bits[0] = 1'b0;
		u_host.wr(8'h81, 8'hff);
		u_host.wr(8'h82, {5'd1, 3'd0});
		u_host.wr(8'h80, 8'h01);
		span(1'b0, n);
		// one pwm period of slack for phase quantisation
		span(1'b1, n);
		check("on time", n > 64 * 255 - 256 && n < 64 * 255 + 256, 1);
		span(1'b0, n);
		check("off time", n > 64 * 255 - 256 && n < 64 * 255 + 256, 1);
	endtask : t_blink
	initial
	begin
		ref_clk = 0; rst_n = 0; osc_tick = 1; osc_source = 2'h2;
		// pin 0 cannot fade, so log mode must leave its levels linear
		led_clk_div = 3'h1; log_mode_a = 1; log_mode_b = 0;
		led_enable_bits = 8'h00; pin_dir = 8'hff; pin_data_bits = 8'hff;
		key_on = 0; key_row = 0; key_col = 0; errors = 0; compares = 0;
		repeat (10) @(posedge ref_clk);
		@(negedge ref_clk);
		rst_n = 1;
		rchk(kslp_pkg::ADDR_KEY_CFG, 8'h00);
		rchk(kslp_pkg::ADDR_KEY_CODE, 8'hff);
		rchk(kslp_pkg::ADDR_SW_RESET, 8'h00);
		rchk(8'h81, 8'hff);
		rchk(8'h30, 8'h00);
		t_swrst;
		key_try(8'h28, 2'd1, 2'd1, 8'hdd);
		key_try(8'h28, 2'd1, 2'd2, 8'hff);
		key_try(8'h28, 2'd2, 2'd0, 8'hff);
		key_try(8'h78, 2'd3, 2'd3, 8'h77);
		key_try(8'h52, 2'd2, 2'd2, 8'hbb);
		key_try(8'h18, 2'd0, 2'd0, 8'hff);
		check("scan off", row_oe_n, 4'hf);
		for (int t = 0; t < 4; t++)
			row_time(3'(t));
		t_levels;
		t_blink;
		close_out;
	end
	initial
	begin
		repeat (95000) @(posedge ref_clk);
		errors++;
		close_out;
	end
endmodule : tb
bind kslp_engine kslp_chk u_chk (.ref_clk(ref_clk), .rst_n(rst_n),
	.reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
	.reg_rd(reg_rd), .reg_rdata(reg_rdata), .osc_source(osc_source),
	.led_clk_div(led_clk_div), .led_enable_bits(led_enable_bits),
	.pin_dir(pin_dir), .led_drive(led_drive), .led_active(led_active),
	.row_drive(row_drive), .row_oe_n(row_oe_n), .irq_out_n(irq_out_n),
	.high_input_enable(high_input_enable),
	.device_reset_req(device_reset_req));
